// ---- brr_pkg.sv ----
// Shared constants and types for branch resolution and register rotation
package brr_pkg;

    // Widths and register file geometry
    localparam int ADDR_W      = 64;
    localparam int DISP_W      = 21;
    localparam int BR_COUNT    = 8;
    localparam int BUNDLE_LSB  = 4;
    localparam logic [63:0] BUNDLE_BYTES = 64'h0000_0000_0000_0010;
    localparam logic [1:0]  SLOT_LOOP    = 2'h2;

    // Rotating regions
    localparam logic [7:0] GR_ROT_BASE = 8'h20;
    localparam logic [7:0] FR_ROT_BASE = 8'h20;
    localparam logic [7:0] FR_ROT_SIZE = 8'h60;
    localparam logic [7:0] PR_ROT_BASE = 8'h10;
    localparam logic [7:0] PR_ROT_SIZE = 8'h30;
    localparam logic [5:0] PR_TOP      = 6'h3F;
    localparam logic [6:0] SOR_MAX     = 7'h60;

    // Register map, byte addresses
    localparam logic [7:0] REG_LC_LO   = 8'h00;
    localparam logic [7:0] REG_LC_HI   = 8'h04;
    localparam logic [7:0] REG_EC      = 8'h08;
    localparam logic [7:0] REG_RRB     = 8'h0C;
    localparam logic [7:0] REG_SOR     = 8'h10;
    localparam logic [7:0] REG_STATUS  = 8'h14;

    // Field positions
    localparam int RRB_GR_LSB  = 0;
    localparam int RRB_FR_LSB  = 8;
    localparam int RRB_PR_LSB  = 16;
    localparam int ST_FAULT    = 0;
    localparam int ST_LEGACY   = 1;

    // Reset values
    localparam logic [63:0] LC_RST = 64'h0;
    localparam logic [5:0]  EC_RST = 6'h0;

    typedef enum logic [3:0] {
        OP_NONE       = 4'h0,
        OP_COND_JUMP  = 4'h1,
        OP_COND_CALL  = 4'h2,
        OP_COND_RET   = 4'h3,
        OP_ISA_SWITCH = 4'h4,
        OP_SIMPLE_LP  = 4'h5,
        OP_MOD_CTOP   = 4'h6,
        OP_MOD_CEXIT  = 4'h7,
        OP_MOD_WTOP   = 4'h8,
        OP_MOD_WEXIT  = 4'h9,
        OP_CLR_ALL    = 4'hA,
        OP_CLR_PRED   = 4'hB,
        OP_JR_TO_GPR  = 4'hC,
        OP_GPR_TO_JR  = 4'hD
    } brr_op_e;

    typedef struct packed {
        brr_op_e             op;
        logic [1:0]          slot;
        logic [5:0]          qp;
        logic                indirect;
        logic [DISP_W-1:0]   disp;
        logic [2:0]          bsrc;
        logic [2:0]          bdst;
        logic [ADDR_W-1:0]   ip;
    } brr_req_s;

    typedef struct packed {
        logic                redirect;
        logic [ADDR_W-1:0]   target;
        logic                flush;
        logic                isa_switch;
        logic                fault;
        logic                stack_call;
        logic                stack_ret;
        logic                gr_we;
        logic [ADDR_W-1:0]   gr_data;
    } brr_res_s;

endpackage

// ---- brr_unit.sv ----
// Branch resolution, jump registers and rotating register rename bases
// Functional notes
// - Targets are bundle aligned; execution resumes at slot zero.
// - A taken branch squashes later instructions of its group.
// - IP-relative target adds signed 21-bit bundle displacement to bundle.
// - Indirect target comes from the selected jump register.
// - Conditional jump taken when its predicate reads one.
// - Taken call writes link address and adjusts register stack.
// - Return is indirect conditional jump plus stack adjustment.
// - Predicate zero always reads one.
// - ISA switch is unconditional, indirect, enters legacy set.
// - Simple loop: nonzero count decrements and takes; zero falls through.
// - Loop branches only in slot two; else illegal operation fault.
// - Moves between jump registers and general registers.
// - Predicates 16-63 and floats 32-127 rotate in fixed regions.
// - General rotating region starts at 32; size zero or multiple of 8.
// - Clear form zeroes all three bases; predicate form only one.
// - Modulo loop branch rotates by one toward higher numbers, wrapping.
// - Rotation renames through three bases in the frame marker.
// - General file rotates only if sized; others always rotate.
// - Each base decrements modulo its own region size.
// - Counted modulo loop, count nonzero: continue, decrement, pr16 one.
// - Count zero, epilog above one: continue, decrement epilog, pr16 zero.
// - Both counts zero: exit, nothing rotates, pr63 written zero.
// - While loop with predicate one: continue, rotate, pr16 zero.
`timescale 1ns/1ps
module brr_unit
    import brr_pkg::*;
#(
    parameter int NBR = BR_COUNT
)(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    // Branch issue
    input  wire logic              i_req_valid,
    input  wire brr_req_s          i_req,
    input  wire logic [63:0]       i_gpr_value,
    // Frame allocation
    input  wire logic              i_alloc_valid,
    input  wire logic [6:0]        i_alloc_sor,
    // Predicate writes and rename lookups
    input  wire logic              i_pr_we,
    input  wire logic [5:0]        i_pr_lnum,
    input  wire logic              i_pr_wval,
    input  wire logic [6:0]        i_gr_lnum,
    input  wire logic [6:0]        i_fr_lnum,
    output logic [6:0]             o_gr_pnum,
    output logic [6:0]             o_fr_pnum,
    output logic [63:0]            o_pred_file,
    // Branch result
    output brr_res_s               o_res,
    // Avalon-MM slave
    input  wire logic [7:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic [31:0]            o_avs_readdata,
    output logic                   o_avs_waitrequest
);

    logic [63:0]   br_r [NBR];
    logic [63:0]   pr_r;
    logic [63:0]   lc_r;
    logic [5:0]    ec_r;
    logic [6:0]    rrb_gr_r;
    logic [6:0]    rrb_fr_r;
    logic [5:0]    rrb_pr_r;
    logic [6:0]    sor_r;
    logic          fault_r;
    logic          legacy_r;
    logic          ack_r;
    logic [31:0]   rdata_r;

    // Renamed index inside a region; sum stays below twice the size
    function automatic logic [7:0] ren(input logic [7:0] l,
                                       input logic [7:0] base,
                                       input logic [7:0] rrb,
                                       input logic [7:0] size);
        logic [7:0] s;
        s = 8'h00;
        if (size == 8'h00 || l < base || l >= base + size) begin
            return l;
        end
        s = (l - base) + rrb;
        if (s >= size) begin
            s = s - size;
        end
        return base + s;
    endfunction

    function automatic logic [7:0] dec_mod(input logic [7:0] v,
                                           input logic [7:0] size);
        return (v == 8'h00) ? size - 8'h01 : v - 8'h01;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                m[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return m;
    endfunction

    function automatic logic [5:0] pr_phys(input logic [5:0] l,
                                           input logic [5:0] rrb);
        logic [7:0] p;
        p = ren({2'h0, l}, PR_ROT_BASE, {2'h0, rrb}, PR_ROT_SIZE);
        return p[5:0];
    endfunction

    // Decode of the issued branch
    logic          qp_val;
    logic [63:0]   tgt_rel;
    logic [63:0]   tgt_ind;
    logic          taken;
    logic [63:0]   target;
    logic          rotate;
    logic          wr63;
    logic          v63;
    logic          lc_dec;
    logic          ec_dec;
    logic          fault;
    logic          clr_all;
    logic          clr_pr;
    logic          do_call;
    logic          do_ret;
    logic          do_isa;
    logic          gr_we;
    logic          br_we;
    logic          cont;
    logic          loop_op;
    logic [5:0]    p63;

    always_comb begin
        qp_val  = pr_r[pr_phys(i_req.qp, rrb_pr_r)];
        tgt_rel = {i_req.ip[63:BUNDLE_LSB] +
                   {{(60-DISP_W){i_req.disp[DISP_W-1]}}, i_req.disp},
                   4'h0};
        tgt_ind = {br_r[i_req.bsrc][63:BUNDLE_LSB], 4'h0};
        target  = i_req.indirect ? tgt_ind : tgt_rel;
        taken   = 1'b0;
        rotate  = 1'b0;
        wr63    = 1'b0;
        v63     = 1'b0;
        lc_dec  = 1'b0;
        ec_dec  = 1'b0;
        fault   = 1'b0;
        clr_all = 1'b0;
        clr_pr  = 1'b0;
        do_call = 1'b0;
        do_ret  = 1'b0;
        do_isa  = 1'b0;
        gr_we   = 1'b0;
        br_we   = 1'b0;
        cont    = 1'b0;
        loop_op = i_req.op inside {OP_SIMPLE_LP, OP_MOD_CTOP,
                  OP_MOD_CEXIT, OP_MOD_WTOP, OP_MOD_WEXIT};
        if (!i_req_valid) begin
            taken = 1'b0;
        end else if (loop_op && i_req.slot != SLOT_LOOP) begin
            fault = 1'b1;
        end else begin
            case (i_req.op)
                OP_COND_JUMP: taken = qp_val;
                OP_COND_CALL: begin
                    taken   = qp_val;
                    do_call = qp_val;
                    br_we   = qp_val;
                end
                OP_COND_RET: begin
                    target = tgt_ind;
                    taken  = qp_val;
                    do_ret = qp_val;
                end
                OP_ISA_SWITCH: begin
                    target = tgt_ind;
                    taken  = 1'b1;
                    do_isa = 1'b1;
                end
                OP_SIMPLE_LP: begin
                    target = tgt_rel;
                    taken  = (lc_r != 64'h0);
                    lc_dec = taken;
                end
                OP_MOD_CTOP, OP_MOD_CEXIT: begin
                    target = tgt_rel;
                    wr63   = 1'b1;
                    if (lc_r != 64'h0) begin
                        cont   = 1'b1;
                        lc_dec = 1'b1;
                        rotate = 1'b1;
                        v63    = 1'b1;
                    end else if (ec_r != 6'h0) begin
                        cont   = (ec_r > 6'h1);
                        ec_dec = 1'b1;
                        rotate = 1'b1;
                    end
                    // both zero: exit, v63 stays zero, no rotate
                    taken = (i_req.op == OP_MOD_CTOP) ? cont : !cont;
                end
                OP_MOD_WTOP, OP_MOD_WEXIT: begin
                    target = tgt_rel;
                    wr63   = 1'b1;
                    if (qp_val) begin
                        cont   = 1'b1;
                        rotate = 1'b1;
                    end else if (ec_r != 6'h0) begin
                        cont   = (ec_r > 6'h1);
                        ec_dec = 1'b1;
                        rotate = 1'b1;
                    end
                    taken = (i_req.op == OP_MOD_WTOP) ? cont : !cont;
                end
                OP_CLR_ALL:   clr_all = 1'b1;
                OP_CLR_PRED:  clr_pr  = 1'b1;
                OP_JR_TO_GPR: gr_we   = 1'b1;
                OP_GPR_TO_JR: br_we   = 1'b1;
                default:      taken   = 1'b0;
            endcase
        end
        p63 = pr_phys(PR_TOP, rrb_pr_r);
    end

    // Avalon bus decode
    logic          bus_acc;
    logic          bus_wr;
    logic [31:0]   rd_mux;

    assign bus_acc = i_avs_read | i_avs_write;
    assign bus_wr  = i_avs_write & ack_r;
    assign o_avs_waitrequest = bus_acc & ~ack_r;
    assign o_avs_readdata    = rdata_r;

    always_comb begin
        rd_mux = 32'h0;
        if (i_avs_address == REG_LC_LO) begin
            rd_mux = lc_r[31:0];
        end else if (i_avs_address == REG_LC_HI) begin
            rd_mux = lc_r[63:32];
        end else if (i_avs_address == REG_EC) begin
            rd_mux[5:0] = ec_r;
        end else if (i_avs_address == REG_RRB) begin
            rd_mux[RRB_GR_LSB +: 7] = rrb_gr_r;
            rd_mux[RRB_FR_LSB +: 7] = rrb_fr_r;
            rd_mux[RRB_PR_LSB +: 6] = rrb_pr_r;
        end else if (i_avs_address == REG_SOR) begin
            rd_mux[6:0] = sor_r;
        end else if (i_avs_address == REG_STATUS) begin
            rd_mux[ST_FAULT]  = fault_r;
            rd_mux[ST_LEGACY] = legacy_r;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r <= bus_acc & ~ack_r;
            if (i_avs_read && !ack_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // Loop and epilog counts; a bus write beats a same-cycle decrement
    logic [31:0] lc_lo_w;
    logic [31:0] lc_hi_w;
    logic [31:0] ec_w;
    assign lc_lo_w = merge(lc_r[31:0], i_avs_writedata, i_avs_byteenable);
    assign lc_hi_w = merge(lc_r[63:32], i_avs_writedata, i_avs_byteenable);
    assign ec_w    = merge({26'h0, ec_r}, i_avs_writedata, i_avs_byteenable);

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            lc_r <= LC_RST;
        end else if (bus_wr && i_avs_address == REG_LC_LO) begin
            lc_r <= {lc_r[63:32], lc_lo_w};
        end else if (bus_wr && i_avs_address == REG_LC_HI) begin
            lc_r <= {lc_hi_w, lc_r[31:0]};
        end else if (lc_dec) begin
            lc_r <= lc_r - 64'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ec_r <= EC_RST;
        end else if (bus_wr && i_avs_address == REG_EC) begin
            ec_r <= ec_w[5:0];
        end else if (ec_dec) begin
            ec_r <= ec_r - 6'h1;
        end
    end

    // Sticky status; hardware set wins over a write-one clear
    logic st_clr_f;
    logic st_clr_l;
    assign st_clr_f = bus_wr && i_avs_address == REG_STATUS &&
                      i_avs_byteenable[0] && i_avs_writedata[ST_FAULT];
    assign st_clr_l = bus_wr && i_avs_address == REG_STATUS &&
                      i_avs_byteenable[0] && i_avs_writedata[ST_LEGACY];

    logic alloc_bad;
    assign alloc_bad = i_alloc_valid &&
                       (i_alloc_sor[2:0] != 3'h0 || i_alloc_sor > SOR_MAX);

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            fault_r  <= 1'b0;
            legacy_r <= 1'b0;
        end else begin
            fault_r  <= (fault_r & ~st_clr_f) | fault | alloc_bad;
            legacy_r <= (legacy_r & ~st_clr_l) | do_isa;
        end
    end

    // Rotating region size from frame allocation
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sor_r <= 7'h0;
        end else if (i_alloc_valid && !alloc_bad) begin
            sor_r <= i_alloc_sor;
        end
    end

    // Rotation bases; clears and calls beat rotation
    logic [7:0] gr_dec;
    logic [7:0] fr_dec;
    logic [7:0] pr_dec;
    assign gr_dec = dec_mod({1'b0, rrb_gr_r}, {1'b0, sor_r});
    assign fr_dec = dec_mod({1'b0, rrb_fr_r}, FR_ROT_SIZE);
    assign pr_dec = dec_mod({2'h0, rrb_pr_r}, PR_ROT_SIZE);

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rrb_gr_r <= 7'h0;
            rrb_fr_r <= 7'h0;
            rrb_pr_r <= 6'h0;
        end else if (clr_all || do_call) begin
            rrb_gr_r <= 7'h0;
            rrb_fr_r <= 7'h0;
            rrb_pr_r <= 6'h0;
        end else if (clr_pr) begin
            rrb_pr_r <= 6'h0;
        end else if (rotate) begin
            if (sor_r != 7'h0) begin
                rrb_gr_r <= gr_dec[6:0];
            end
            rrb_fr_r <= fr_dec[6:0];
            rrb_pr_r <= pr_dec[5:0];
        end
    end

    // Predicate file kept physically; the loop value is written to the
    // slot that reads as the top predicate now and as 16 after rotation
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pr_r <= 64'h1;
        end else begin
            if (i_pr_we) begin
                pr_r[pr_phys(i_pr_lnum, rrb_pr_r)] <= i_pr_wval;
            end
            if (wr63) begin
                pr_r[p63] <= v63;
            end
            pr_r[0] <= 1'b1;
        end
    end
    assign o_pred_file = pr_r;

    // Jump register file
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            for (int k = 0; k < NBR; k++) begin
                br_r[k] <= 64'h0;
            end
        end else if (br_we) begin
            br_r[i_req.bdst] <= do_call ? i_req.ip + BUNDLE_BYTES
                                        : i_gpr_value;
        end
    end

    // Rename lookups for the register files
    logic [7:0] gr_p;
    logic [7:0] fr_p;
    assign gr_p = ren({1'b0, i_gr_lnum}, GR_ROT_BASE, {1'b0, rrb_gr_r},
                      {1'b0, sor_r});
    assign fr_p = ren({1'b0, i_fr_lnum}, FR_ROT_BASE, {1'b0, rrb_fr_r},
                      FR_ROT_SIZE);

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_gr_pnum <= 7'h0;
            o_fr_pnum <= 7'h0;
        end else begin
            o_gr_pnum <= gr_p[6:0];
            o_fr_pnum <= fr_p[6:0];
        end
    end

    // Registered branch result
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_res <= '0;
        end else begin
            o_res.redirect   <= taken;
            o_res.target     <= target;
            o_res.flush      <= taken;
            o_res.isa_switch <= do_isa;
            o_res.fault      <= fault;
            o_res.stack_call <= do_call;
            o_res.stack_ret  <= do_ret;
            o_res.gr_we      <= gr_we;
            o_res.gr_data    <= br_r[i_req.bsrc];
        end
    end

endmodule

// ---- brr_unit_monitor.sv ----
// Concurrent checks on the branch unit ports
`timescale 1ns/1ps
module brr_unit_monitor
    import brr_pkg::*;
#(
    parameter int NBR = BR_COUNT
)(
    // Clock, reset and issue
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_req_valid,
    input  wire brr_req_s    i_req,
    // Results and bus handshake
    input  wire brr_res_s    o_res,
    input  wire logic [63:0] o_pred_file,
    input  wire logic        i_avs_read,
    input  wire logic        o_avs_waitrequest
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic [63:0] rel_tgt;
    logic        lp;
    logic        p0;
    assign rel_tgt = i_req.ip + {{39{i_req.disp[20]}}, i_req.disp, 4'h0};
    assign lp = i_req.op inside {[OP_SIMPLE_LP:OP_MOD_WEXIT]};
    assign p0 = i_req_valid && i_req.qp == 6'h00;
    a_target_aligned:
        assert property (o_res.redirect |-> o_res.target[3:0] == 4'h0)
        else $error("target not bundle aligned");
    a_flush_follows:
        assert property (o_res.flush == o_res.redirect)
        else $error("flush differs from redirect");
    a_iprel_target:
        assert property (p0 && i_req.op == OP_COND_JUMP && !i_req.indirect
            |=> o_res.redirect && o_res.target == $past(rel_tgt))
        else $error("relative target wrong");
    a_pred_zero_set:
        assert property (o_pred_file[0] == 1'b1)
        else $error("predicate zero not one");
    a_loop_slot_fault:
        assert property (i_req_valid && lp && i_req.slot != SLOT_LOOP
            |=> o_res.fault && !o_res.redirect)
        else $error("loop op outside slot two not refused");
    a_isa_switch_go:
        assert property (i_req_valid && i_req.op == OP_ISA_SWITCH
            |=> o_res.isa_switch && o_res.redirect)
        else $error("set switch not taken");
    a_call_stack_adj:
        assert property (p0 && i_req.op == OP_COND_CALL
            |=> o_res.stack_call && o_res.redirect)
        else $error("call without stack adjust");
    a_ret_stack_adj:
        assert property (p0 && i_req.op == OP_COND_RET
            |=> o_res.stack_ret && o_res.redirect)
        else $error("return without stack adjust");
    a_idle_quiet:
        assert property (!i_req_valid |=> !o_res.redirect && !o_res.fault)
        else $error("result without request");
    a_bus_one_wait:
        assert property ($rose(i_avs_read)
            |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("read wait not one cycle");
    c_redirect: cover property (o_res.redirect);
    c_fault: cover property (o_res.fault);
    c_switch: cover property (o_res.isa_switch);
endmodule

bind brr_unit brr_unit_monitor #(.NBR(NBR)) u_mon (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_req_valid(i_req_valid),
    .i_req(i_req),
    .o_res(o_res),
    .o_pred_file(o_pred_file),
    .i_avs_read(i_avs_read),
    .o_avs_waitrequest(o_avs_waitrequest)
);

// ---- testbench.sv ----
// Self-checking bench for the branch and rotation unit
`timescale 1ns/1ps
module testbench
    import brr_pkg::*;
;
    logic        i_clk, i_rstn, i_req_valid, i_alloc_valid, i_pr_we;
    logic        i_pr_wval, i_avs_read, i_avs_write, o_avs_waitrequest;
    logic [5:0]  i_pr_lnum;
    logic [6:0]  i_alloc_sor, i_gr_lnum, i_fr_lnum, o_gr_pnum, o_fr_pnum;
    logic [7:0]  i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata;
    logic [31:0] rs = 32'h0000_000D;
    logic [63:0] i_gpr_value, o_pred_file, lc;
    logic [63:0] jr [8];
    logic [15:0] preds;
    brr_req_s    i_req;
    brr_res_s    o_res;
    int          ec, rg, rf, rp, sor, n_errors, cmp_count, cyc;

    always #12.5 i_clk = ~i_clk;

    brr_unit u_brr_unit (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_req_valid(i_req_valid), .i_req(i_req), .i_gpr_value(i_gpr_value),
        .i_alloc_valid(i_alloc_valid), .i_alloc_sor(i_alloc_sor),
        .i_pr_we(i_pr_we), .i_pr_lnum(i_pr_lnum), .i_pr_wval(i_pr_wval),
        .i_gr_lnum(i_gr_lnum), .i_fr_lnum(i_fr_lnum), .o_gr_pnum(o_gr_pnum),
        .o_fr_pnum(o_fr_pnum), .o_pred_file(o_pred_file), .o_res(o_res),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest));

    function automatic logic [63:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return {rs, ~rs};
    endfunction

    function automatic logic [31:0] rrb();
        return (32'(rp) << 16) | (32'(rf) << 8) | 32'(rg);
    endfunction

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic test_done();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Low loop count and epilog count writes also go to the model; high loop count writes do not
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] e);
        @(posedge i_clk);
        i_avs_read <= !w;
        i_avs_write <= w;
        i_avs_address <= a;
        i_avs_writedata <= d;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        if (!w) chk(o_avs_readdata, e);
        i_avs_read <= 0;
        i_avs_write <= 0;
        if (w && a == REG_LC_LO) lc[31:0] = d;
        if (w && a == REG_EC) ec = d[5:0];
    endtask

    task automatic rot();
        if (sor != 0) rg = (rg + sor - 1) % sor;
        rf = (rf + 95) % 96;
        rp = (rp + 47) % 48;
    endtask

    task automatic issue(input brr_op_e op, input logic [1:0] sl,
        input logic [5:0] qp, input logic ind, input logic [63:0] ip,
        input logic [20:0] dp, input logic [2:0] bs, input logic [2:0] bd);
        logic        tk, pq, fl;
        logic [63:0] tg, gd, gv;
        tk = 0;
        fl = 0;
        gd = jr[bs];
        gv = rnd();
        pq = (qp == 0) || preds[qp[3:0]];
        tg = ind ? {jr[bs][63:4], 4'h0} : ip + {{39{dp[20]}}, dp, 4'h0};
        @(posedge i_clk);
        i_req_valid <= 1;
        i_req <= '{op, sl, qp, ind, dp, bs, bd, ip};
        i_gpr_value <= gv;
        @(posedge i_clk);
        i_req_valid <= 0;
        if (op inside {[OP_SIMPLE_LP:OP_MOD_WEXIT]} && sl != SLOT_LOOP) fl = 1;
        else case (op)
            OP_COND_JUMP, OP_COND_RET: tk = pq;
            OP_COND_CALL: begin
                tk = pq;
                jr[bd] = pq ? ip + 16 : jr[bd];
                if (pq) rg = 0;
                if (pq) rf = 0;
                if (pq) rp = 0;
            end
            OP_ISA_SWITCH: tk = 1;
            OP_SIMPLE_LP: if (lc != 0) begin
                lc--;
                tk = 1;
            end
            OP_MOD_CTOP, OP_MOD_WTOP, OP_MOD_CEXIT:
            if (op != OP_MOD_WTOP ? lc != 0 : pq) begin
                tk = 1;
                if (op != OP_MOD_WTOP) lc--;
                rot();
            end else if (ec != 0) begin
                tk = ec > 1;
                ec--;
                rot();
            end
            OP_CLR_ALL: rot_clear();
            OP_CLR_PRED: rp = 0;
            OP_GPR_TO_JR: jr[bd] = gv;
            default: ;
        endcase
        if (op == OP_MOD_CEXIT && !fl) tk = !tk;
        @(negedge i_clk);
        chk(o_res.redirect, tk);
        chk(o_res.flush, tk);
        chk(o_res.fault, fl);
        if (tk) chk(o_res.target, tg);
        if (op == OP_JR_TO_GPR) chk(o_res.gr_data, gd);
    endtask

    task automatic rot_clear();
        rg = 0;
        rf = 0;
        rp = 0;
    endtask

    task automatic pin(input logic a, input logic [6:0] n, input logic v);
        @(posedge i_clk);
        i_alloc_valid <= a;
        i_alloc_sor <= n;
        i_pr_we <= !a;
        i_pr_lnum <= n[5:0];
        i_pr_wval <= v;
        @(posedge i_clk);
        i_alloc_valid <= 0;
        i_pr_we <= 0;
        if (a) sor = n;
        else preds[n[3:0]] = v;
    endtask

    // Logical 32 of both files and logical predicate 16 after renaming
    task automatic look(input logic p16);
        @(posedge i_clk);
        i_gr_lnum <= 7'h20;
        i_fr_lnum <= 7'h20;
        @(posedge i_clk);
        @(negedge i_clk);
        chk(o_gr_pnum, 32 + rg);
        chk(o_fr_pnum, 32 + rf);
        chk(o_pred_file[16 + rp], p16);
    endtask

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        {i_clk, i_rstn, i_req_valid, i_alloc_valid, i_pr_we, i_pr_wval} = '0;
        {i_avs_read, i_avs_write, i_pr_lnum, i_alloc_sor} = '0;
        {i_gr_lnum, i_fr_lnum, i_avs_address, i_avs_writedata} = '0;
        {i_gpr_value, lc, preds} = '0;
        i_req = '0;
        foreach (jr[i]) jr[i] = '0;
        repeat (10) @(posedge i_clk);
        i_rstn <= 1;
        bus(1, 8'h20, 32'hFFFF_FFFF, 0);
        for (int a = 0; a <= 32; a += 4) bus(0, a[7:0], 0, 0);
        for (int i = 0; i < 8; i++)
            issue(OP_COND_JUMP, i[1:0], 0, 0, rnd() & ~64'hF, 21'(rnd()), 0, 0);
        issue(OP_COND_JUMP, 0, 0, 0, 64'h40, 21'h0F_FFFF, 0, 0);
        issue(OP_COND_JUMP, 0, 0, 0, 64'h40, 21'h10_0000, 0, 0);
        pin(0, 5, 0);
        issue(OP_COND_JUMP, 2, 5, 0, 64'h1000, 21'h3, 0, 0);
        pin(0, 5, 1);
        issue(OP_COND_JUMP, 2, 5, 0, 64'h1000, 21'h3, 0, 0);
        issue(OP_GPR_TO_JR, 0, 0, 0, 0, 0, 0, 3);
        issue(OP_JR_TO_GPR, 0, 0, 0, 0, 0, 3, 0);
        issue(OP_COND_JUMP, 1, 0, 1, 0, 0, 3, 0);
        issue(OP_COND_RET, 1, 0, 1, 0, 0, 3, 0);
        issue(OP_COND_CALL, 0, 0, 0, 64'hABC0, 21'h1F_FFFF, 0, 4);
        issue(OP_JR_TO_GPR, 0, 0, 0, 0, 0, 4, 0);
        issue(OP_ISA_SWITCH, 2, 0, 1, 0, 0, 3, 0);
        issue(OP_SIMPLE_LP, 0, 0, 0, 64'h40, 21'h1, 0, 0);
        bus(0, REG_STATUS, 0, 3);
        bus(1, REG_STATUS, 3, 0);
        bus(0, REG_STATUS, 0, 0);
        bus(1, REG_LC_LO, 2, 0);
        repeat (3) issue(OP_SIMPLE_LP, 2, 0, 0, 64'h40, 21'h1F_FFFE, 0, 0);
        bus(0, REG_LC_LO, 0, 0);
        bus(1, REG_LC_LO, 1, 0);
        pin(0, 16, 1);
        issue(OP_MOD_CTOP, 2, 0, 0, 64'h80, 21'h1F_FFFF, 0, 0);
        look(1);
        bus(1, REG_EC, 2, 0);
        repeat (3) issue(OP_MOD_CTOP, 2, 0, 0, 64'h80, 21'h1F_FFFF, 0, 0);
        look(0);
        bus(0, REG_RRB, 0, rrb());
        bus(0, REG_EC, 0, 0);
        issue(OP_MOD_CEXIT, 2, 0, 0, 64'h80, 21'h1F_FFFF, 0, 0);
        issue(OP_CLR_PRED, 2, 0, 0, 0, 0, 0, 0);
        bus(0, REG_RRB, 0, rrb());
        issue(OP_CLR_ALL, 2, 0, 0, 0, 0, 0, 0);
        pin(1, 8, 0);
        bus(0, REG_SOR, 0, 8);
        bus(1, REG_LC_LO, 1, 0);
        issue(OP_MOD_CTOP, 2, 0, 0, 64'h80, 21'h1F_FFFF, 0, 0);
        issue(OP_MOD_WTOP, 2, 0, 0, 64'h80, 21'h1F_FFFF, 0, 0);
        look(0);
        bus(0, REG_RRB, 0, rrb());
        test_done();
    end
endmodule
